//--- design/uum_core.sv
// User unit scaling, loop ticks and motion range limiting
`timescale 1ns/10ps
`default_nettype none
module uum_core import uum_pkg::*; #(
	parameter int CUR_CYCLES = CUR_CYC
) (
	input  wire logic               i_clk,       // 200 MHz clock
	input  wire logic               i_rstn,      // Async reset, active low
	input  wire logic               i_obj_wr,    // Object write strobe
	input  wire logic               i_obj_rd,    // Object read strobe
	input  wire logic        [15:0] i_obj_idx,   // Object index
	input  wire logic        [7:0]  i_obj_sub,   // Object subindex
	input  wire logic        [31:0] i_obj_wdata, // Write data
	output logic             [31:0] o_obj_rdata, // Read data
	output logic                    o_obj_ack,   // Access done pulse
	input  wire logic               i_op_en,     // Operation enabled state
	input  wire logic               i_lim_pos,   // Positive limit switch
	input  wire logic               i_lim_neg,   // Negative limit switch
	input  wire logic signed [31:0] i_act_pos,   // Actual position
	input  wire logic               i_tgt_vld,   // Target request pulse
	input  wire logic signed [31:0] i_tgt_pos,   // Absolute target
	output logic signed      [31:0] o_tgt_pos,   // Clamped target
	output logic                    o_tgt_vld,   // Target accepted pulse
	output logic                    o_tgt_rej,   // Target refused pulse
	output logic                    o_cur_tick,  // Current loop tick
	output logic                    o_vel_tick,  // Velocity loop tick
	output logic                    o_app_tick,  // Application tick
	output logic                    o_warn,      // Status warning bit
	output logic                    o_blk_pos,   // Positive travel blocked
	output logic                    o_blk_neg,   // Negative travel blocked
	output logic             [1:0]  o_stop_ramp, // Stop ramp pulse
	output logic             [1:0]  o_stop_end,  // Stop end state pulse
	output logic                    o_qs_bit,    // Quick-stop control bit
	output logic             [31:0] o_enc_res,   // Encoder resolution
	output logic             [31:0] o_gear,      // Gear ratio
	output logic             [31:0] o_feed,      // Feed constant
	output logic                    o_feed_use,  // Feed constant applies
	output logic             [7:0]  o_pos_unit,  // Position unit code
	output logic signed      [7:0]  o_pos_exp,   // Position exponent
	output logic             [7:0]  o_spd_unit,  // Speed position unit
	output logic signed      [7:0]  o_spd_exp,   // Speed exponent
	output logic             [7:0]  o_time_unit, // Speed time unit code
	output logic             [31:0] o_time_sec,  // Seconds per time unit
	output logic             [31:0] o_vel_num,   // Speed factor numerator
	output logic             [31:0] o_vel_den,   // Speed factor denominator
	output logic             [31:0] o_acc_num,   // Accel factor numerator
	output logic             [31:0] o_acc_den,   // Accel factor denominator
	output logic             [31:0] o_jrk_num,   // Jerk factor numerator
	output logic             [31:0] o_jrk_den    // Jerk factor denominator
);
	localparam int CW = $clog2(CUR_CYCLES);
	localparam int SW = $clog2(APP_DIV);
	localparam int VW = $clog2(VEL_DIV);

	logic [CW-1:0]    cur_cnt_q;
	logic [SW-1:0]    sub_q;
	logic             cur_wrap;
	logic             app_wrap;
	logic [31:0]      pend_q [NOBJ];
	logic [31:0]      act_q [NOBJ];
	logic [NOBJ-1:0]  hit;
	logic [31:0]      ctrl_q;
	logic [31:0]      rd_d;
	logic             lp_q;
	logic             ln_q;
	uum_ls_t          ls_q;
	logic             side_q;
	logic signed [31:0] trip_q;
	logic signed [31:0] tgt_q;
	logic             tgt_pend_q;
	logic signed [31:0] smin;
	logic signed [31:0] smax;
	logic             rise_p;
	logic             rise_n;

	// Loop ticks share one divider so they stay phase aligned
	assign cur_wrap = cur_cnt_q == CW'(CUR_CYCLES - 1);
	assign app_wrap = cur_wrap && sub_q == SW'(APP_DIV - 1);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cur_cnt_q <= '0;
			sub_q <= '0;
			o_cur_tick <= 1'b0;
			o_vel_tick <= 1'b0;
			o_app_tick <= 1'b0;
		end else begin
			cur_cnt_q <= cur_wrap ? '0 : cur_cnt_q + 1'b1;
			if (cur_wrap) begin
				sub_q <= sub_q + 1'b1;
			end
			o_cur_tick <= cur_wrap;
			o_vel_tick <= cur_wrap && sub_q[VW-1:0] == '1;
			o_app_tick <= app_wrap;
		end
	end

	// Object store: host writes land in pending, applied on the tick
	generate
		for (genvar g = 0; g < NOBJ; g++) begin : g_obj
			assign hit[g] = i_obj_idx == OBJ_IDX[g] && i_obj_sub == OBJ_SUB[g];
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					pend_q[g] <= OBJ_RST[g];
					act_q[g] <= OBJ_RST[g];
				end else begin
					// A zero divisor would poison every derived ratio
					if (i_obj_wr && hit[g] && !(OBJ_DEN[g] && i_obj_wdata == '0)) begin
						pend_q[g] <= i_obj_wdata;
					end
					if (app_wrap && !(OBJ_UNIT[g] && i_op_en)) begin
						act_q[g] <= pend_q[g];
					end
				end
			end
		end
	endgenerate

	// Control word only changes on host writes, never by the device
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_q <= '0;
			o_qs_bit <= 1'b0;
		end else begin
			if (i_obj_wr && i_obj_idx == IDX_CTRL && i_obj_sub == 8'h00) begin
				ctrl_q <= i_obj_wdata;
			end
			o_qs_bit <= ctrl_q[QS_BIT];
		end
	end

	// Read mux returns pending values, so a host sees its own write
	always_comb begin
		rd_d = '0;
		for (int k = 0; k < NOBJ; k++) begin
			if (hit[k]) begin
				rd_d = pend_q[k];
			end
		end
		if (i_obj_sub == 8'h00 && i_obj_idx == IDX_CTRL) begin
			rd_d = ctrl_q;
		end
		if (i_obj_sub == 8'h00 && i_obj_idx == IDX_STAT) begin
			rd_d = 32'(o_warn) << WARN_BIT;
		end
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_obj_rdata <= '0;
			o_obj_ack <= 1'b0;
		end else begin
			o_obj_ack <= i_obj_wr || i_obj_rd;
			if (i_obj_rd) begin
				o_obj_rdata <= rd_d;
			end
		end
	end

	// Derived scaling; divisors are never zero so plain division is safe
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_enc_res <= '0;
			o_gear <= '0;
			o_feed <= '0;
			o_feed_use <= 1'b0;
			o_pos_unit <= '0;
			o_pos_exp <= '0;
			o_spd_unit <= '0;
			o_spd_exp <= '0;
			o_time_unit <= '0;
			o_time_sec <= '0;
		end else if (app_wrap) begin
			o_enc_res <= act_q[S_ENCI] / act_q[S_MREV];
			o_gear <= act_q[S_GMOT] / act_q[S_GDRV];
			o_feed <= act_q[S_FEED] / act_q[S_FREV];
			o_feed_use <= act_q[S_POSU][PUNIT_LSB+:8] inside {PU_M, PU_IN, PU_FT, PU_NONE};
			o_pos_unit <= act_q[S_POSU][PUNIT_LSB+:8];
			o_pos_exp <= act_q[S_POSU][EXP_LSB+:8];
			o_spd_unit <= act_q[S_SPDU][PUNIT_LSB+:8];
			o_spd_exp <= act_q[S_SPDU][EXP_LSB+:8];
			o_time_unit <= act_q[S_SPDU][TUNIT_LSB+:8];
			unique case (act_q[S_SPDU][TUNIT_LSB+:8])
				TU_SEC:  o_time_sec <= 32'd1;
				TU_MIN:  o_time_sec <= 32'd60;
				TU_HOUR: o_time_sec <= 32'd3600;
				TU_DAY:  o_time_sec <= 32'd86400;
				TU_YEAR: o_time_sec <= 32'd31557600;
				default: o_time_sec <= 32'd0;
			endcase
		end
	end

	// Factor pairs leave as ratios; the profile side does the divide
	assign o_vel_num = act_q[S_VNUM];
	assign o_vel_den = act_q[S_VDEN];
	assign o_acc_num = act_q[S_ANUM];
	assign o_acc_den = act_q[S_ADEN];
	assign o_jrk_num = act_q[S_JNUM];
	assign o_jrk_den = act_q[S_JDEN];

	// Limit switches; edges only seen at tick resolution
	assign rise_p = i_lim_pos && !lp_q;
	assign rise_n = i_lim_neg && !ln_q;
	assign o_blk_pos = lp_q;
	assign o_blk_neg = ln_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lp_q <= 1'b0;
			ln_q <= 1'b0;
			ls_q <= LS_CLR;
			side_q <= 1'b0;
			trip_q <= '0;
			o_warn <= 1'b0;
			o_stop_ramp <= RAMP_NONE;
			o_stop_end <= END_NONE;
		end else begin
			o_stop_ramp <= RAMP_NONE;
			o_stop_end <= END_NONE;
			if (app_wrap) begin
				lp_q <= i_lim_pos;
				ln_q <= i_lim_neg;
				unique case (ls_q)
					LS_CLR: if (rise_p || rise_n) begin
						ls_q <= LS_HIT;
						side_q <= rise_p;
						trip_q <= i_act_pos;
						o_warn <= 1'b1;
						unique case (act_q[S_LREA])
							RE_SLOW_DIS: begin
								o_stop_ramp <= RAMP_SLOW;
								o_stop_end <= END_DIS;
							end
							RE_QUICK_DIS: begin
								o_stop_ramp <= RAMP_QUICK;
								o_stop_end <= END_DIS;
							end
							RE_SLOW_QS: begin
								o_stop_ramp <= RAMP_SLOW;
								o_stop_end <= END_QSA;
							end
							RE_QUICK_QS: begin
								o_stop_ramp <= RAMP_QUICK;
								o_stop_end <= END_QSA;
							end
							default: o_stop_ramp <= RAMP_NONE;
						endcase
					end
					LS_HIT: if (!i_lim_pos && !i_lim_neg) begin
						ls_q <= LS_OFF;
					end
					LS_OFF: if (i_lim_pos || i_lim_neg) begin
						ls_q <= LS_HIT;
					end else if (side_q ? i_act_pos < trip_q : i_act_pos > trip_q) begin
						ls_q <= LS_CLR;
						o_warn <= 1'b0;
					end
					default: ls_q <= LS_CLR;
				endcase
			end
		end
	end

	// Target check: one request held until the next tick, newest wins
	assign smin = act_q[S_SMIN];
	assign smax = act_q[S_SMAX];
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tgt_q <= '0;
			tgt_pend_q <= 1'b0;
			o_tgt_pos <= '0;
			o_tgt_vld <= 1'b0;
			o_tgt_rej <= 1'b0;
		end else begin
			o_tgt_vld <= 1'b0;
			o_tgt_rej <= 1'b0;
			if (app_wrap && tgt_pend_q) begin
				tgt_pend_q <= 1'b0;
				if ((tgt_q > i_act_pos && (i_lim_pos || i_act_pos > smax)) ||
					(tgt_q < i_act_pos && (i_lim_neg || i_act_pos < smin))) begin
					o_tgt_rej <= 1'b1;
				end else begin
					o_tgt_vld <= 1'b1;
					o_tgt_pos <= tgt_q > smax ? smax : (tgt_q < smin ? smin : tgt_q);
				end
			end
			// A new request in the tick cycle is kept, not dropped
			if (i_tgt_vld) begin
				tgt_q <= i_tgt_pos;
				tgt_pend_q <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	tgt_clamp_a: assert property (o_tgt_vld |-> o_tgt_pos <= $past(smax) && o_tgt_pos >= $past(smin))
		else $error("target outside software limits");
	warn_set_a: assert property (app_wrap && ls_q == LS_CLR && rise_p |=> o_warn && o_blk_pos)
		else $error("warning not set on limit switch");
	warn_hold_a: assert property (o_warn && (lp_q || ln_q) |=> o_warn)
		else $error("warning cleared while switch active");
	blk_pos_a: assert property (app_wrap && tgt_pend_q && i_lim_pos && tgt_q > i_act_pos
		|=> o_tgt_rej && !o_tgt_vld)
		else $error("travel toward active switch accepted");
	react_q_a: assert property (app_wrap && ls_q == LS_CLR && rise_n && act_q[S_LREA] == RE_QUICK_QS
		|=> o_stop_ramp == RAMP_QUICK && o_stop_end == END_QSA)
		else $error("quick stop reaction not issued");
	unit_hold_a: assert property (app_wrap && i_op_en |=> act_q[S_POSU] == $past(act_q[S_POSU]))
		else $error("unit changed in operation enabled");
	den_zero_a: assert property (i_obj_wr && hit[S_VDEN] && i_obj_wdata == '0
		|=> pend_q[S_VDEN] == $past(pend_q[S_VDEN]) && pend_q[S_VDEN] != '0)
		else $error("zero denominator accepted");
	tick_nest_a: assert property (o_app_tick |-> o_vel_tick && o_cur_tick ##1 !o_cur_tick)
		else $error("loop ticks misaligned");
	qs_keep_a: assert property (!(i_obj_wr && i_obj_idx == IDX_CTRL) ##1 $fell(ctrl_q[QS_BIT]) |-> 1'b0)
		else $error("quick-stop bit cleared by device");
endmodule
`default_nettype wire

//--- design/uum_pkg.sv
// Constants for user unit scaling and motion limits
// Notes on behaviour
// - Encoder resolution is encoder increments divided by motor revolutions.
// - Gear ratio is motor shaft revolutions divided by driving shaft revolutions.
// - Feed constant is feed per output turn, used for length or dimensionless units.
// - Bits 16..23 of both unit words hold the position unit code.
// - Bits 24..31 of each unit word are a signed power-of-ten exponent.
// - Bits 8..15 of the speed unit word hold the time unit code.
// - Speed unit scaled by speed factor numerator over denominator.
// - Acceleration unit is speed unit per second, scaled by its own factor.
// - Jerk unit is acceleration unit per second, scaled by its own factor.
// - Passing a limit switch sets warning bit 7 and runs the reaction.
// - Reaction -1 none; 1,2 slow/quick then disabled; 5,6 slow/quick then quick stop.
// - While a switch is active, motion toward it is blocked, away allowed.
// - Warning clears only after switch releases and position passes back.
// - Quick-stop control bit 2 is never cleared by the device.
// - Absolute targets are clamped to the software minimum and maximum.
// - Outside the software range only travel toward the range is accepted.
// - Objects and inputs are sampled once per 1 ms application tick.
// - Current loop every 62.5 us, velocity every 250 us, position every 1 ms.
// - Unit and scaling changes wait until operation enabled is left.
// - Time unit codes 03 s, 47 min, 48 h, 49 day, 4A year.
package uum_pkg;
	// Loop periods in ns and the clock period
	localparam int CLK_PER_NS = 5;
	localparam int CUR_PER_NS = 62500;
	localparam int VEL_PER_NS = 250000;
	localparam int APP_PER_NS = 1000000;
	localparam int CUR_CYC    = CUR_PER_NS / CLK_PER_NS;
	localparam int VEL_DIV    = VEL_PER_NS / CUR_PER_NS;
	localparam int APP_DIV    = APP_PER_NS / CUR_PER_NS;
	// Object slots: index, subindex, reset value
	localparam int NOBJ = 17;
	localparam int S_POSU = 0, S_SPDU = 1, S_ENCI = 2, S_MREV = 3, S_GMOT = 4, S_GDRV = 5;
	localparam int S_FEED = 6, S_FREV = 7, S_VNUM = 8, S_VDEN = 9, S_ANUM = 10, S_ADEN = 11;
	localparam int S_JNUM = 12, S_JDEN = 13, S_LREA = 14, S_SMIN = 15, S_SMAX = 16;
	localparam logic [15:0] OBJ_IDX [NOBJ] = '{16'h60a8, 16'h60a9, 16'h60e6, 16'h60eb,
		16'h60e8, 16'h60ed, 16'h60e9, 16'h60ee, 16'h6096, 16'h6096, 16'h6097, 16'h6097,
		16'h60a2, 16'h60a2, 16'h3701, 16'h607d, 16'h607d};
	localparam logic [7:0] OBJ_SUB [NOBJ] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02};
	localparam logic [31:0] OBJ_RST [NOBJ] = '{32'hff410000, 32'h00b44700, 32'h00000001,
		32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
		32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'hffffffff,
		32'h80000000, 32'h7fffffff};
	localparam logic [NOBJ-1:0] OBJ_DEN  = 17'h02aa8;
	localparam logic [NOBJ-1:0] OBJ_UNIT = 17'h03fff;
	localparam logic [15:0] IDX_CTRL = 16'h6040;
	localparam logic [15:0] IDX_STAT = 16'h6041;
	localparam int QS_BIT = 2;
	localparam int WARN_BIT = 7;
	// Unit word fields
	localparam int EXP_LSB = 24, PUNIT_LSB = 16, TUNIT_LSB = 8;
	// Time unit codes
	localparam logic [7:0] TU_SEC = 8'h03, TU_MIN = 8'h47, TU_HOUR = 8'h48;
	localparam logic [7:0] TU_DAY = 8'h49, TU_YEAR = 8'h4a;
	// Length-based or dimensionless position units
	localparam logic [7:0] PU_M = 8'h01, PU_IN = 8'hc1, PU_FT = 8'hc2, PU_NONE = 8'h00;
	// Limit switch reaction codes and their outputs
	localparam logic [31:0] RE_SLOW_DIS = 32'h00000001, RE_QUICK_DIS = 32'h00000002;
	localparam logic [31:0] RE_SLOW_QS = 32'h00000005, RE_QUICK_QS = 32'h00000006;
	localparam logic [1:0] RAMP_NONE = 2'h0, RAMP_SLOW = 2'h1, RAMP_QUICK = 2'h2;
	localparam logic [1:0] END_NONE = 2'h0, END_DIS = 2'h1, END_QSA = 2'h2;
	typedef enum logic [1:0] {LS_CLR, LS_HIT, LS_OFF} uum_ls_t;
endpackage

//--- verification/testbench.sv
// Self-checking bench for unit scaling and motion limits
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int CC = 4; // Short loop period keeps the run brief
	logic               i_clk, i_rstn, i_obj_wr, i_obj_rd, i_op_en, i_lim_pos, i_lim_neg;
	logic               i_tgt_vld, o_obj_ack, o_tgt_vld, o_tgt_rej, o_cur_tick, o_vel_tick;
	logic               o_app_tick, o_warn, o_blk_pos, o_blk_neg, o_qs_bit, o_feed_use;
	logic        [1:0]  o_stop_ramp, o_stop_end;
	logic        [15:0] i_obj_idx;
	logic        [7:0]  i_obj_sub, o_pos_unit, o_spd_unit, o_time_unit;
	logic signed [7:0]  o_pos_exp, o_spd_exp;
	logic        [31:0] i_obj_wdata, o_obj_rdata, o_enc_res, o_gear, o_feed, o_time_sec, q;
	logic        [31:0] o_vel_num, o_vel_den, o_acc_num, o_acc_den, o_jrk_num, o_jrk_den;
	logic signed [31:0] i_act_pos, i_tgt_pos, o_tgt_pos;
	logic        [15:0] fidx [3] = '{16'h6096, 16'h6097, 16'h60a2};
	logic        [7:0]  tcode [5] = '{8'h03, 8'h47, 8'h48, 8'h49, 8'h4a};
	logic        [31:0] tsec [5] = '{32'd1, 32'd60, 32'd3600, 32'd86400, 32'd31557600};
	logic        [31:0] rcode [5] = '{32'hffffffff, 32'h1, 32'h2, 32'h5, 32'h6};
	logic        [1:0]  rramp [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
	logic        [1:0]  rend [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	int                 n_mismatch = 0;
	int                 num_checks = 0;

	uum_core #(.CUR_CYCLES(CC)) u_dut (.*);
	uum_host u_host (
		.i_clk       (i_clk),
		.o_obj_wr    (i_obj_wr),
		.o_obj_rd    (i_obj_rd),
		.o_obj_idx   (i_obj_idx),
		.o_obj_sub   (i_obj_sub),
		.o_obj_wdata (i_obj_wdata),
		.i_obj_rdata (o_obj_rdata),
		.i_obj_ack   (o_obj_ack)
	);
	// 200 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	function automatic logic tk(input int k);
		return k == 0 ? o_cur_tick : (k == 1 ? o_vel_tick : o_app_tick);
	endfunction
	// Cycles from one tick pulse to the next, bounded against a dead counter
	task automatic gap(input int k, output int n);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (tk(k) !== 1'b1 && n < 300);
	endtask
	task automatic tick();
		int n;
		gap(2, n);
		if (n >= 300)
			chk("app tick", 32'h1, 32'h0);
	endtask
	// Two target pulses in one tick; only the later one counts
	task automatic tgt(input int act, input int t1, input int t2, input logic ok,
			input int e);
		tick();
		@(posedge i_clk);
		i_act_pos <= act;
		i_tgt_vld <= 1'b1;
		i_tgt_pos <= t1;
		@(posedge i_clk);
		i_tgt_pos <= t2;
		@(posedge i_clk);
		i_tgt_vld <= 1'b0;
		tick();
		chk("target taken", 32'(ok), 32'(o_tgt_vld));
		chk("target refused", 32'(!ok), 32'(o_tgt_rej));
		if (ok)
			chk("target pos", e, o_tgt_pos);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Whole run is near 85 app ticks of 64 cycles; about three times that cuts a hang
	initial begin
		#80000;
		n_mismatch++;
		results();
	end
	initial begin
		int n;
		i_rstn = 1'b0;
		i_op_en = 1'b0;
		i_lim_pos = 1'b0;
		i_lim_neg = 1'b0;
		i_act_pos = 0;
		i_tgt_vld = 1'b0;
		i_tgt_pos = 0;
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		u_host.rd(16'h60a8, 8'h00, q);
		chk("pos unit reset", 32'hff410000, q);
		u_host.rd(16'h60a9, 8'h00, q);
		chk("spd unit reset", 32'h00b44700, q);
		chk("speed num reset", 32'h1, o_vel_num);
		for (int k = 0; k < 3; k++) begin
			gap(k, n);
			gap(k, n);
			chk("tick gap", 32'(CC << (2 * k)), 32'(n));
		end
		$display("test reset and ticks done");
		// Ratios, units and factors, with a zero divisor that must be dropped
		u_host.wr(16'h60e6, 8'h00, 32'd1000);
		u_host.wr(16'h60eb, 8'h00, 32'd4);
		u_host.wr(16'h60e8, 8'h00, 32'd10);
		u_host.wr(16'h60ed, 8'h00, 32'd3);
		u_host.wr(16'h60e9, 8'h00, 32'd20);
		u_host.wr(16'h60ee, 8'h00, 32'd5);
		u_host.wr(16'h60eb, 8'h00, 32'h0);
		u_host.wr(16'h60a8, 8'h00, 32'hfd010000);
		u_host.wr(16'h60a9, 8'h00, 32'hfd010300);
		for (int i = 0; i < 3; i++) begin
			u_host.wr(fidx[i], 8'h01, 32'(i + 2));
			u_host.wr(fidx[i], 8'h02, 32'(i + 7));
		end
		u_host.wr(16'h6096, 8'h02, 32'h0);
		tick();
		tick();
		chk("enc res", 32'd250, o_enc_res);
		chk("gear", 32'd3, o_gear);
		chk("feed", 32'd4, o_feed);
		chk("feed use", 32'h1, 32'(o_feed_use));
		chk("pos unit", 32'h01, 32'(o_pos_unit));
		chk("pos exp", 32'hfd, {24'h0, o_pos_exp});
		chk("spd unit", 32'h01, 32'(o_spd_unit));
		chk("spd exp", 32'hfd, {24'h0, o_spd_exp});
		chk("time unit", 32'h03, 32'(o_time_unit));
		u_host.rd(16'h60eb, 8'h00, q);
		chk("divisor kept", 32'd4, q);
		chk("speed num", 32'd2, o_vel_num);
		chk("speed den", 32'd7, o_vel_den);
		chk("acc num", 32'd3, o_acc_num);
		chk("acc den", 32'd8, o_acc_den);
		chk("jerk num", 32'd4, o_jrk_num);
		chk("jerk den", 32'd9, o_jrk_den);
		for (int i = 0; i < 5; i++) begin
			u_host.wr(16'h60a9, 8'h00, {16'h0001, tcode[i], 8'h00});
			tick();
			tick();
			chk("time secs", tsec[i], o_time_sec);
		end
		$display("test units done");
		// Unit change held while operation is enabled
		@(posedge i_clk);
		i_op_en <= 1'b1;
		u_host.wr(16'h60a8, 8'h00, 32'hff410000);
		tick();
		tick();
		chk("unit held", 32'h01, 32'(o_pos_unit));
		@(posedge i_clk);
		i_op_en <= 1'b0;
		tick();
		tick();
		chk("unit applied", 32'h41, 32'(o_pos_unit));
		chk("feed unused", 32'h0, 32'(o_feed_use));
		$display("test pending units done");
		// Every reaction code on the positive switch
		u_host.wr(16'h607d, 8'h01, 32'hfffffc18);
		u_host.wr(16'h607d, 8'h02, 32'd1000);
		for (int i = 0; i < 5; i++) begin
			u_host.wr(16'h3701, 8'h00, rcode[i]);
			u_host.wr(16'h6040, 8'h00, 32'h4);
			tick();
			@(posedge i_clk);
			i_act_pos <= 100;
			i_lim_pos <= 1'b1;
			tick();
			chk("warn set", 32'h1, 32'(o_warn));
			chk("stop ramp", 32'(rramp[i]), 32'(o_stop_ramp));
			chk("stop end", 32'(rend[i]), 32'(o_stop_end));
			chk("qs kept", 32'h1, 32'(o_qs_bit));
			u_host.rd(16'h6041, 8'h00, q);
			chk("status", 32'h80, q);
			tgt(100, 200, 200, 1'b0, 0);
			chk("pos blocked", 32'h1, 32'(o_blk_pos));
			tgt(100, 50, 50, 1'b1, 50);
			@(posedge i_clk);
			i_lim_pos <= 1'b0;
			tick();
			tick();
			chk("warn held", 32'h1, 32'(o_warn));
			@(posedge i_clk);
			i_act_pos <= 90;
			tick();
			tick();
			chk("warn cleared", 32'h0, 32'(o_warn));
			u_host.qs_cycle();
		end
		// Negative switch under the last reaction code, quick stop then quick-stop-active
		@(posedge i_clk);
		i_act_pos <= -100;
		i_lim_neg <= 1'b1;
		tick();
		chk("neg warn set", 32'h1, 32'(o_warn));
		chk("neg stop ramp", 32'h2, 32'(o_stop_ramp));
		chk("neg stop end", 32'h2, 32'(o_stop_end));
		chk("neg blocked", 32'h1, 32'(o_blk_neg));
		tgt(-100, -200, -200, 1'b0, 0);
		tgt(-100, 0, 0, 1'b1, 0);
		@(posedge i_clk);
		i_lim_neg <= 1'b0;
		i_act_pos <= -90;
		tick();
		tick();
		chk("neg warn cleared", 32'h0, 32'(o_warn));
		chk("neg unblocked", 32'h0, 32'(o_blk_neg));
		$display("test limit switch done");
		tgt(0, 5000, 5000, 1'b1, 1000);
		tgt(0, 5000, -5000, 1'b1, -1000);
		tgt(2000, 3000, 3000, 1'b0, 0);
		tgt(2000, 1500, 1500, 1'b1, 1000);
		chk("ack missing", 32'h0, 32'(u_host.n_noack));
		$display("test software limits done");
		results();
	end
endmodule
`default_nettype wire

//--- verification/uum_host.sv
// Host model that reads and writes configuration objects
`timescale 1ns/10ps
`default_nettype none
module uum_host (
	input  wire logic        i_clk,       // Bench clock
	output logic             o_obj_wr,    // Write strobe
	output logic             o_obj_rd,    // Read strobe
	output logic      [15:0] o_obj_idx,   // Object index
	output logic      [7:0]  o_obj_sub,   // Object subindex
	output logic      [31:0] o_obj_wdata, // Write data
	input  wire logic [31:0] i_obj_rdata, // Read data
	input  wire logic        i_obj_ack    // Access done pulse
);
	int n_noack = 0;
	// Idle bus at time zero
	initial begin
		o_obj_wr = 1'b0;
		o_obj_rd = 1'b0;
		o_obj_idx = 16'h0;
		o_obj_sub = 8'h0;
		o_obj_wdata = 32'h0;
	end
	// One access; released lines show inverted values so stale data never matches
	task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		o_obj_wr <= w;
		o_obj_rd <= !w;
		o_obj_idx <= idx;
		o_obj_sub <= sub;
		o_obj_wdata <= d;
		@(posedge i_clk);
		o_obj_wr <= 1'b0;
		o_obj_rd <= 1'b0;
		o_obj_idx <= ~idx;
		o_obj_sub <= ~sub;
		o_obj_wdata <= ~d;
		@(negedge i_clk);
		if (i_obj_ack !== 1'b1)
			n_noack++;
		q = i_obj_rdata;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
		logic [31:0] junk;
		acc(1'b1, idx, sub, d, junk);
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] sub, output logic [31:0] q);
		acc(1'b0, idx, sub, 32'h0, q);
	endtask
	// Leaving quick stop needs the control bit low, then high again
	task automatic qs_cycle();
		wr(16'h6040, 8'h00, 32'h0);
		wr(16'h6040, 8'h00, 32'h4);
	endtask
endmodule
`default_nettype wire
